// ===== rtl/aid_pkg.sv
`default_nettype none
package aid_pkg;
	// datapath and bus widths
	localparam int DATA_W = 16;
	localparam int DW_W = 32;
	localparam int NUM_GPR = 8;
	localparam int GPR_IDX_W = 3;
	localparam int INSTR_WORDS = 3;
	localparam int INSTR_IDX_W = 2;
	localparam int IND_W = 5;
	localparam int AM_W = 2;
	localparam int BUS_W = 32;
	localparam int SEL_W = 4;
	localparam logic [SEL_W-1:0] SEL_LOW16 = 4'h3;
	// operand sizes in bytes, byte-to-word index shift
	localparam logic [DATA_W-1:0] WORD_BYTES = 16'h0002;
	localparam logic [DATA_W-1:0] DWORD_BYTES = 16'h0004;
	localparam int WORD_SHIFT = 1;
	localparam int ALIGN_BIT = 0;
	localparam logic [GPR_IDX_W-1:0] LAST_GPR = 3'h7;
	localparam logic [GPR_IDX_W-1:0] GPR_ZERO = 3'h0;
	// operation codes, instruction bits 0-4
	localparam logic [4:0] OPC_REG_GROUP = 5'h0e;
	localparam logic [4:0] OPC_AD_RS = 5'h1a;
	localparam logic [4:0] OPC_AW_RS = 5'h19;
	localparam logic [4:0] OPC_AW_LONG = 5'h0d;
	localparam logic [4:0] OPC_SS = 5'h15;
	// function codes
	localparam logic [4:0] FUN_ACY = 5'h0c;
	localparam logic [4:0] FUN_AW_RR = 5'h00;
	localparam logic [2:0] FUN_RS = 3'h6;
	localparam logic [3:0] FUN_LONG = 4'he;
	localparam logic [1:0] FUN_SS_AD = 2'h2;
	localparam logic [1:0] FUN_SS_AW = 2'h0;
	// address modes
	localparam logic [AM_W-1:0] AM_REG = 2'h0;
	localparam logic [AM_W-1:0] AM_POSTINC = 2'h1;
	localparam logic [AM_W-1:0] AM_DISP = 2'h2;
	localparam logic [AM_W-1:0] AM_INDIRECT = 2'h3;
	// field positions in the first instruction word (bit 0 of the word is the msb)
	localparam int F_OPC_HI = 15, F_OPC_LO = 11;
	localparam int F_R_HI = 10, F_R_LO = 8, F_R2_HI = 7, F_R2_LO = 5;
	localparam int F_RB_HI = 7, F_RB_LO = 6, F_AM_HI = 5, F_AM_LO = 4;
	localparam int F_X = 3, F_IND = 4;
	localparam int F_RB1_HI = 10, F_RB1_LO = 9, F_RB2_HI = 8, F_RB2_LO = 7;
	localparam int F_AM1_HI = 6, F_AM1_LO = 5, F_AM2_HI = 4, F_AM2_LO = 3;
	localparam int F_FUN5_HI = 4, F_FUN4_HI = 3, F_FUN3_HI = 2, F_FUN2_HI = 1;
	// program check status word positions (status bit 0 is the msb)
	localparam int PSW_SPEC = 15, PSW_ISA = 14, PSW_INVF = 11;
	// indicator positions
	localparam int IND_CARRY = 4, IND_OVF = 3, IND_EVEN = 2, IND_NEG = 1, IND_ZERO = 0;
	// register byte offsets
	localparam int REG_STRIDE = 4;
	localparam int ADDR_LSB = 2;
	localparam int REG_CTRL = 32'h0000_0000;
	localparam int REG_STATUS = 32'h0000_0004;
	localparam int REG_PCHECK = 32'h0000_0008;
	localparam int REG_IND = 32'h0000_000c;
	localparam int REG_INSTR0 = 32'h0000_0010;
	localparam int REG_IAR = 32'h0000_001c;
	localparam int REG_GPR_BASE = 32'h0000_0020;
	localparam int REG_MEM_BASE = 32'h0000_0400;
	localparam int CTRL_START = 0;
	localparam int STATUS_BUSY = 0, STATUS_DONE = 1;
	typedef enum logic [0:0] {AID_IDLE, AID_EXEC} aid_state_type;
endpackage
`default_nettype wire

// ===== rtl/aid_adder.sv
`timescale 1ns/10ps
`default_nettype none
module aid_adder #(
	parameter int W = 16
) (
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	input wire logic cin,
	output logic [W-1:0] sum,
	output logic carry,
	output logic ovf
);
	logic [W:0] wide;

	// carry out equals the true sign of the sum whenever signed overflow occurs
	assign wide = (W+1)'(a) + (W+1)'(b) + (W+1)'(cin);
	assign sum = wide[W-1:0];
	assign carry = wide[W];
	// overflow only when both inputs share a sign that the sum lost
	assign ovf = (a[W-1] == b[W-1]) && (sum[W-1] != a[W-1]);
endmodule
`default_nettype wire

// ===== rtl/aid_datapath.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - add-carry adds entry carry to the second-field register, writes it back there
// - add-carry keeps even, sets negative, zero only stays on if already on
// - word adds set carry from carry out of bit 15, else clear
// - word adds clear overflow, set it when signed sum leaves 16-bit range
// - word overflow keeps low 16 sum bits, carry holds true sign
// - word and doubleword adds set even, negative, zero from result
// - register/storage doubleword adds register pair to storage doubleword
// - register field 7 pairs register 7 with register 0
// - bit 12 set sends result to storage, clear to registers
// - doubleword carry from bit 31 carry out, overflow beyond 32-bit range
// - doubleword overflow keeps low 32 bits, carry holds true sign
// - storage/storage doubleword adds operand 1 into operand 2 only
// - doubleword invalid address terminates; same bases and mode 01 increments register
// - storage/storage word adds operand 1 into operand 2 only
// - word invalid address terminates; mode 01 and bad operand 2 increments base 1
// - register/register word adds first register into second register
// - long format bit 11 selects direct or indirect address; adds into first register
// - long address adds second-field register unless that field is zero
// - storage forms flag invalid storage address in instruction or operand
// - storage forms flag specification check for odd indirect or operand address
// - add-carry and register/register add never raise a program check
// - specification check sets status bit 0
// - address beyond installed storage sets status bit 1
// - suppressed instructions change nothing, terminated ones may change some
module aid_datapath #(
	parameter int ADR_W = 12,
	parameter int MEM_WORDS = 256,
	parameter int INSTALLED_BYTES = 512
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [aid_pkg::SEL_W-1:0] wb_sel_i,
	input wire logic [aid_pkg::BUS_W-1:0] wb_dat_i,
	output logic [aid_pkg::BUS_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	output logic busy_o
);
	import aid_pkg::*;
	localparam int MEM_AW = $clog2(MEM_WORDS);

	logic [DATA_W-1:0] gpr [NUM_GPR];
	logic [DATA_W-1:0] mem [MEM_WORDS];
	logic [DATA_W-1:0] iw [INSTR_WORDS];
	logic [DATA_W-1:0] iar;
	logic [DATA_W-1:0] pcheck;
	logic [IND_W-1:0] ind;
	logic done;
	aid_state_type state;
	function automatic logic [MEM_AW-1:0] widx(input logic [DATA_W-1:0] a);
		return a[MEM_AW+WORD_SHIFT-1:WORD_SHIFT];
	endfunction
	function automatic logic [MEM_AW-1:0] widx_next(input logic [DATA_W-1:0] a);
		return MEM_AW'(widx(a) + MEM_AW'(1));
	endfunction
	// a span of n bytes at a lies wholly inside installed storage
	function automatic logic fits(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] n);
		return ((DATA_W+1)'(a) + (DATA_W+1)'(n)) <= (DATA_W+1)'(INSTALLED_BYTES);
	endfunction
	function automatic logic appended(input logic [AM_W-1:0] am);
		return (am == AM_DISP) || (am == AM_INDIRECT);
	endfunction
	function automatic logic [DATA_W-1:0] ea_pre(input logic [AM_W-1:0] am,
		input logic [DATA_W-1:0] base, input logic [DATA_W-1:0] disp);
		return appended(am) ? DATA_W'(base + disp) : base;
	endfunction

	// instruction decode
	wire [4:0] opc = iw[0][F_OPC_HI:F_OPC_LO];
	wire [GPR_IDX_W-1:0] f_r = iw[0][F_R_HI:F_R_LO];
	wire [GPR_IDX_W-1:0] f_r2 = iw[0][F_R2_HI:F_R2_LO];
	wire [GPR_IDX_W-1:0] f_rb = {1'b0, iw[0][F_RB_HI:F_RB_LO]};
	wire [GPR_IDX_W-1:0] f_rb1 = {1'b0, iw[0][F_RB1_HI:F_RB1_LO]};
	wire [GPR_IDX_W-1:0] f_rb2 = {1'b0, iw[0][F_RB2_HI:F_RB2_LO]};
	wire [AM_W-1:0] f_am = iw[0][F_AM_HI:F_AM_LO];
	wire [AM_W-1:0] f_am1 = iw[0][F_AM1_HI:F_AM1_LO];
	wire [AM_W-1:0] f_am2 = iw[0][F_AM2_HI:F_AM2_LO];
	wire f_x = iw[0][F_X];
	wire f_ind = iw[0][F_IND];
	wire is_acy = opc == OPC_REG_GROUP && iw[0][F_FUN5_HI:0] == FUN_ACY;
	wire is_awrr = opc == OPC_REG_GROUP && iw[0][F_FUN5_HI:0] == FUN_AW_RR;
	wire is_rs = (opc == OPC_AW_RS || opc == OPC_AD_RS) && iw[0][F_FUN3_HI:0] == FUN_RS;
	wire is_long = opc == OPC_AW_LONG && iw[0][F_FUN4_HI:0] == FUN_LONG;
	wire is_ss = opc == OPC_SS && (iw[0][F_FUN2_HI:0] == FUN_SS_AD ||
		iw[0][F_FUN2_HI:0] == FUN_SS_AW);
	wire dw = (is_rs && opc == OPC_AD_RS) || (is_ss && iw[0][F_FUN2_HI:0] == FUN_SS_AD);
	wire is_storage = is_rs || is_long || is_ss;
	wire invf = !(is_acy || is_awrr || is_storage);
	wire [DATA_W-1:0] size = dw ? DWORD_BYTES : WORD_BYTES;

	// first storage operand address; long form adds r2 unless field is zero
	wire [AM_W-1:0] am_a = is_ss ? f_am1 : f_am;
	wire [GPR_IDX_W-1:0] rb_a = is_ss ? f_rb1 : f_rb;
	wire [DATA_W-1:0] long_pre = DATA_W'(iw[1] + ((f_r2 == GPR_ZERO) ? '0 : gpr[f_r2]));
	wire [DATA_W-1:0] pre_a = is_long ? long_pre : ea_pre(am_a, gpr[rb_a], iw[1]);
	wire ind_a = is_long ? f_ind : (am_a == AM_INDIRECT);
	wire [DATA_W-1:0] ea_a = ind_a ? mem[widx(pre_a)] : pre_a;
	wire app_a = is_long || appended(am_a);

	// second operand sees base 1 already stepped when both bases coincide and operand 1 uses mode 01
	wire same_post = f_rb1 == f_rb2 && f_am1 == AM_POSTINC;
	wire [DATA_W-1:0] base_b = DATA_W'(gpr[f_rb2] + (same_post ? size : '0));
	wire [DATA_W-1:0] pre_b = ea_pre(f_am2, base_b, app_a ? iw[2] : iw[1]);
	wire ind_b = f_am2 == AM_INDIRECT;
	wire [DATA_W-1:0] ea_b = ind_b ? mem[widx(pre_b)] : pre_b;
	wire app_b = is_ss && appended(f_am2);

	// exception detection, only for storage forms
	wire [DATA_W-1:0] instr_bytes = DATA_W'((1 + 32'(app_a) + 32'(app_b)) * 2);
	wire isa_instr = is_storage && !fits(iar, instr_bytes);
	wire isa_a = is_storage && ((ind_a && !fits(pre_a, WORD_BYTES)) || !fits(ea_a, size));
	wire isa_b = is_ss && ((ind_b && !fits(pre_b, WORD_BYTES)) || !fits(ea_b, size));
	wire spec_a = is_storage && ((ind_a && pre_a[ALIGN_BIT]) || ea_a[ALIGN_BIT]);
	wire spec_b = is_ss && ((ind_b && pre_b[ALIGN_BIT]) || ea_b[ALIGN_BIT]);
	wire isa_any = isa_instr || isa_a || isa_b;
	wire spec_any = spec_a || spec_b;
	wire pc_any = isa_any || spec_any || invf;

	// operand fetch; pair is high word at r, low word at r+1 mod 8
	wire [GPR_IDX_W-1:0] r_next = GPR_IDX_W'(f_r + GPR_IDX_W'(1));
	wire [DW_W-1:0] pair = {gpr[f_r], gpr[r_next]};
	wire [DW_W-1:0] mem_a32 = {mem[widx(ea_a)], mem[widx_next(ea_a)]};
	wire [DW_W-1:0] mem_b32 = {mem[widx(ea_b)], mem[widx_next(ea_b)]};
	wire [DATA_W-1:0] x16 = is_acy ? gpr[f_r2] : (is_ss ? mem[widx(ea_a)] : gpr[f_r]);
	wire [DATA_W-1:0] y16 = is_acy ? '0 : (is_awrr ? gpr[f_r2] :
		(is_ss ? mem[widx(ea_b)] : mem[widx(ea_a)]));
	wire cin16 = is_acy && ind[IND_CARRY];
	wire [DW_W-1:0] x32 = is_ss ? mem_a32 : pair;
	wire [DW_W-1:0] y32 = is_ss ? mem_b32 : mem_a32;

	wire [DATA_W-1:0] sum16;
	wire [DW_W-1:0] sum32;
	wire c16, v16, c32, v32;
	aid_adder #(.W(DATA_W)) u_add16 (
		.a(x16),
		.b(y16),
		.cin(cin16),
		.sum(sum16),
		.carry(c16),
		.ovf(v16)
	);
	aid_adder #(.W(DW_W)) u_add32 (
		.a(x32),
		.b(y32),
		.cin(1'b0),
		.sum(sum32),
		.carry(c32),
		.ovf(v32)
	);
	// indicator results; add-carry keeps even and can only keep zero on
	wire res_zero = dw ? (sum32 == '0) : (sum16 == '0);
	wire res_neg = dw ? sum32[DW_W-1] : sum16[DATA_W-1];
	wire res_even = dw ? !sum32[ALIGN_BIT] : !sum16[ALIGN_BIT];
	logic [IND_W-1:0] next_ind;
	always_comb begin
		next_ind[IND_CARRY] = dw ? c32 : c16;
		next_ind[IND_OVF] = dw ? v32 : v16;
		next_ind[IND_NEG] = res_neg;
		next_ind[IND_EVEN] = is_acy ? ind[IND_EVEN] : res_even;
		next_ind[IND_ZERO] = is_acy ? (ind[IND_ZERO] && res_zero) : res_zero;
	end

	// destination selection
	wire exec = state == AID_EXEC;
	wire ok = exec && !pc_any;
	wire to_mem = (is_rs && f_x) || is_ss;
	wire [DATA_W-1:0] mem_wa = is_ss ? ea_b : ea_a;
	wire wr_mem = ok && to_mem;
	wire wr_reg = ok && !to_mem;
	wire [GPR_IDX_W-1:0] wr_idx = (is_acy || is_awrr) ? f_r2 : f_r;
	wire [DATA_W-1:0] wr_hi = dw ? sum32[DW_W-1:DATA_W] : sum16;
	wire [DATA_W-1:0] wr_lo = sum32[DATA_W-1:0];

	// base register stepping: after success, or on a terminating bad address
	wire term_inc = exec && is_ss && isa_any && !spec_any &&
		(dw ? same_post : (f_am1 == AM_POSTINC && isa_b));
	wire inc1 = (ok && (is_rs || is_ss) && am_a == AM_POSTINC) || term_inc;
	wire inc2 = ok && is_ss && f_am2 == AM_POSTINC;
	wire [DATA_W-1:0] inc1_val = DATA_W'(gpr[rb_a] + size);
	wire [DATA_W-1:0] inc2_val = DATA_W'(base_b + size);

	// register bus decode
	wire bus_req = wb_cyc_i && wb_stb_i;
	wire lanes_ok = (wb_sel_i & SEL_LOW16) == SEL_LOW16;
	wire bus_wr = bus_req && wb_we_i && wb_ack_o && lanes_ok;
	wire idle_wr = bus_wr && !busy_o;
	wire [ADR_W:0] adr_x = {1'b0, wb_adr_i};
	wire hit_gpr = adr_x >= (ADR_W+1)'(REG_GPR_BASE) &&
		adr_x < (ADR_W+1)'(REG_GPR_BASE + NUM_GPR * REG_STRIDE);
	wire hit_mem = adr_x >= (ADR_W+1)'(REG_MEM_BASE) &&
		adr_x < (ADR_W+1)'(REG_MEM_BASE + MEM_WORDS * REG_STRIDE);
	wire hit_instr = adr_x >= (ADR_W+1)'(REG_INSTR0) &&
		adr_x < (ADR_W+1)'(REG_INSTR0 + INSTR_WORDS * REG_STRIDE);
	wire [ADR_W-1:0] gpr_off = ADR_W'(wb_adr_i - ADR_W'(REG_GPR_BASE)) >> ADDR_LSB;
	wire [ADR_W-1:0] mem_off = ADR_W'(wb_adr_i - ADR_W'(REG_MEM_BASE)) >> ADDR_LSB;
	wire [ADR_W-1:0] iw_off = ADR_W'(wb_adr_i - ADR_W'(REG_INSTR0)) >> ADDR_LSB;
	wire [GPR_IDX_W-1:0] gpr_sel = gpr_off[GPR_IDX_W-1:0];
	wire [MEM_AW-1:0] mem_sel = mem_off[MEM_AW-1:0];
	wire [INSTR_IDX_W-1:0] iw_sel = iw_off[INSTR_IDX_W-1:0];
	wire hit_ctrl = wb_adr_i == ADR_W'(REG_CTRL);
	wire hit_iar = wb_adr_i == ADR_W'(REG_IAR);
	wire hit_ind = wb_adr_i == ADR_W'(REG_IND);
	wire start = idle_wr && hit_ctrl && wb_dat_i[CTRL_START];

	// read data; unmapped offsets read as zero
	logic [BUS_W-1:0] rdata;
	always_comb begin
		rdata = '0;
		if (hit_gpr) begin
			rdata[DATA_W-1:0] = gpr[gpr_sel];
		end else if (hit_mem) begin
			rdata[DATA_W-1:0] = mem[mem_sel];
		end else if (hit_instr) begin
			rdata[DATA_W-1:0] = iw[iw_sel];
		end else if (hit_iar) begin
			rdata[DATA_W-1:0] = iar;
		end else if (hit_ind) begin
			rdata[IND_W-1:0] = ind;
		end else if (wb_adr_i == ADR_W'(REG_PCHECK)) begin
			rdata[DATA_W-1:0] = pcheck;
		end else if (wb_adr_i == ADR_W'(REG_STATUS)) begin
			rdata[STATUS_BUSY] = busy_o;
			rdata[STATUS_DONE] = done;
		end
	end

	// classic single-cycle slave: ack one cycle after the strobe, then drop
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= bus_req && !wb_ack_o;
			if (bus_req && !wb_ack_o) begin
				wb_dat_o <= rdata;
			end
		end
	end

	// sequencing: one execute cycle per start
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state <= AID_IDLE;
			busy_o <= 1'b0;
			done <= 1'b0;
		end else if (exec) begin
			state <= AID_IDLE;
			busy_o <= 1'b0;
			done <= 1'b1;
		end else if (start) begin
			state <= AID_EXEC;
			busy_o <= 1'b1;
			done <= 1'b0;
		end
	end

	// status and indicators; a failed instruction leaves indicators as they were
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ind <= '0;
			pcheck <= '0;
			iar <= '0;
		end else if (exec) begin
			pcheck <= '0;
			pcheck[PSW_SPEC] <= spec_any;
			pcheck[PSW_ISA] <= isa_any;
			pcheck[PSW_INVF] <= invf;
			if (!pc_any) begin
				ind <= next_ind;
			end
		end else if (idle_wr && hit_ind) begin
			ind <= wb_dat_i[IND_W-1:0];
		end else if (idle_wr && hit_iar) begin
			iar <= wb_dat_i[DATA_W-1:0];
		end
	end

	// instruction words, loaded by software while idle
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			for (int i = 0; i < INSTR_WORDS; i++) begin
				iw[i] <= '0;
			end
		end else if (idle_wr && hit_instr) begin
			iw[iw_sel] <= wb_dat_i[DATA_W-1:0];
		end
	end

	// general registers; result write comes last so it wins over a base step
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_GPR; i++) begin
				gpr[i] <= '0;
			end
		end else if (exec) begin
			if (inc1) begin
				gpr[rb_a] <= inc1_val;
			end
			if (inc2) begin
				gpr[f_rb2] <= inc2_val;
			end
			if (wr_reg) begin
				gpr[wr_idx] <= wr_hi;
				if (dw) begin
					gpr[r_next] <= wr_lo;
				end
			end
		end else if (idle_wr && hit_gpr) begin
			gpr[gpr_sel] <= wb_dat_i[DATA_W-1:0];
		end
	end

	// storage; no reset since it models main storage contents
	always_ff @(posedge clk_sys) begin
		if (wr_mem) begin
			mem[widx(mem_wa)] <= wr_hi;
			if (dw) begin
				mem[widx_next(mem_wa)] <= wr_lo;
			end
		end else if (idle_wr && hit_mem) begin
			mem[mem_sel] <= wb_dat_i[DATA_W-1:0];
		end
	end

	// checks on the execute cycle and its outcome
	wire [DATA_W:0] chk17 = (DATA_W+1)'(x16) + (DATA_W+1)'(y16) + (DATA_W+1)'(cin16);
	wire [DW_W:0] chk33 = (DW_W+1)'(x32) + (DW_W+1)'(y32);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	a_acy_even_hold: assert property (exec && is_acy |=> $stable(ind[IND_EVEN]))
		else $error("even indicator changed by add-carry");
	a_acy_zero_off: assert property (exec && is_acy && !ind[IND_ZERO] |=> !ind[IND_ZERO])
		else $error("zero indicator turned on by add-carry");
	a_word_carry: assert property (ok && !dw |=> ind[IND_CARRY] == $past(chk17[DATA_W]))
		else $error("word carry wrong");
	a_word_ovf: assert property (ok && !dw |=> ind[IND_OVF] ==
		$past(x16[DATA_W-1] == y16[DATA_W-1] && chk17[DATA_W-1] != x16[DATA_W-1]))
		else $error("word overflow wrong");
	a_dw_carry: assert property (ok && dw |=> ind[IND_CARRY] == $past(chk33[DW_W]))
		else $error("doubleword carry wrong");
	a_rr_dest: assert property (ok && is_awrr |=>
		gpr[$past(f_r2)] == $past(DATA_W'(gpr[f_r] + gpr[f_r2])))
		else $error("register add result wrong");
	a_reg_no_check: assert property (exec && (is_acy || is_awrr) |=> pcheck == '0)
		else $error("program check raised by register form");
	a_suppress_keep: assert property (exec && pc_any |=> $stable(ind) ##1 $stable(ind))
		else $error("indicators changed on failed instruction");
	a_pair_wrap: assert property (ok && is_rs && dw && !f_x && f_r == LAST_GPR |=>
		gpr[GPR_ZERO] == $past(chk33[DATA_W-1:0]))
		else $error("pair low word not in register 0");
	a_spec_bit: assert property (exec && spec_any |=> pcheck[PSW_SPEC])
		else $error("specification bit not set");
	a_exec_done: assert property (start |=> busy_o ##1 (!busy_o && done))
		else $error("execute did not finish in one cycle");
	c_acy_run: cover property (ok && is_acy);
	c_ss_dw_ok: cover property (ok && is_ss && dw);
	c_term_inc: cover property (term_inc);
	c_spec_check: cover property (exec && spec_any && !isa_any);
endmodule
`default_nettype wire

// ===== verif/aid_bus_partner.sv
`timescale 1ns/10ps
`default_nettype none
// software and instruction source on the far side of the register bus
module aid_bus_partner (
	input wire logic clk_sys,
	input wire logic wb_ack,
	input wire logic [31:0] wb_rdat,
	output logic wb_cyc,
	output logic wb_stb,
	output logic wb_we,
	output logic [11:0] wb_adr,
	output logic [3:0] wb_sel,
	output logic [31:0] wb_wdat,
	output logic timed_out
);
	initial begin
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 12'h000;
		wb_sel = 4'h0;
		wb_wdat = 32'h0000_0000;
		timed_out = 1'b0;
	end

	// one classic cycle, held until ack is sampled high or 40 clocks pass
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int i;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_sel <= 4'hf;
		wb_wdat <= d;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (wb_ack !== 1'b1 && i < 40);
		if (wb_ack !== 1'b1) timed_out <= 1'b1;
		q = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		// released address and data lines show their inverted value, never the old value
		wb_adr <= ~a;
		wb_wdat <= ~d;
		@(posedge clk_sys);
	endtask

	// unused bits 5-7 are always sent as zero
	function automatic logic [15:0] acy_word(input logic [2:0] r2);
		return {5'b01110, 3'b000, r2, 5'b01100};
	endfunction
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import aid_pkg::*;
	logic clk_sys, nrst, cyc, stb, we, ack, busy, tmo;
	logic [11:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	int mismatches = 0;
	int n_checks = 0;
	int n_busy = 0;

	// busy_o should stand for exactly one cycle per start; sampled mid-cycle
	always @(negedge clk_sys) begin
		if (busy === 1'b1) n_busy++;
	end

	aid_datapath #(.ADR_W(12), .MEM_WORDS(256), .INSTALLED_BYTES(64)) i_aid_datapath (
		.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .busy_o(busy));
	aid_bus_partner i_aid_bus_partner (
		.clk_sys(clk_sys), .wb_ack(ack), .wb_rdat(rdat), .wb_cyc(cyc), .wb_stb(stb),
		.wb_we(we), .wb_adr(adr), .wb_sel(sel), .wb_wdat(wdat), .timed_out(tmo));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic conclude;
		if (mismatches == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// bus helpers; storage byte b sits at bus byte offset 2*b from the storage base
	task automatic wr(input int a, input logic [31:0] d);
		logic [31:0] q;
		i_aid_bus_partner.xfer(1'b1, 12'(a), d, q);
	endtask
	task automatic ck(input int a, input logic [31:0] e);
		logic [31:0] q;
		i_aid_bus_partner.xfer(1'b0, 12'(a), 32'h0, q);
		chk(q, e);
	endtask
	function automatic int g(input int n);
		return REG_GPR_BASE + 4 * n;
	endfunction
	function automatic int m(input int b);
		return REG_MEM_BASE + 2 * b;
	endfunction

	// load instruction, start, poll done with a bound
	task automatic exec(input logic [15:0] w0, input logic [15:0] w1);
		logic [31:0] q;
		int i;
		wr(REG_INSTR0, {16'h0, w0});
		wr(REG_INSTR0 + 4, {16'h0, w1});
		n_busy = 0;
		wr(REG_CTRL, 32'h1);
		i = 0;
		do begin
			i_aid_bus_partner.xfer(1'b0, 12'(REG_STATUS), 32'h0, q);
			i++;
		end while (q[STATUS_DONE] !== 1'b1 && i < 20);
		if (q[STATUS_DONE] !== 1'b1) begin
			mismatches++;
			conclude;
		end
		chk(32'(n_busy), 32'h1);
	endtask

	task automatic t_acy;
		wr(REG_IND, 32'h14);
		wr(g(3), 32'hffff);
		exec(i_aid_bus_partner.acy_word(3'h3), 16'h0);
		ck(g(3), 32'h0);
		ck(REG_IND, 32'h14);
		ck(REG_PCHECK, 32'h0);
		wr(REG_IND, 32'h11);
		wr(g(3), 32'h7fff);
		exec(i_aid_bus_partner.acy_word(3'h3), 16'h0);
		ck(g(3), 32'h8000);
		ck(REG_IND, 32'h0a);
	endtask

	task automatic t_awrr;
		wr(g(2), 32'h8000);
		wr(g(5), 32'h8000);
		exec({5'b01110, 3'h2, 3'h5, 5'h00}, 16'h0);
		ck(g(5), 32'h0);
		ck(g(2), 32'h8000);
		ck(REG_IND, 32'h1d);
		ck(REG_PCHECK, 32'h0);
	endtask

	// pair 7/0 wraps; high word in register 7, low word in register 0
	task automatic t_ad_rs;
		wr(g(7), 32'h0);
		wr(g(0), 32'h1);
		wr(g(1), 32'h10);
		wr(m(16), 32'hffff);
		wr(m(18), 32'hffff);
		exec({5'b11010, 3'h7, 2'h1, 2'h0, 1'b0, 3'b110}, 16'h0);
		ck(g(7), 32'h0);
		ck(g(0), 32'h0);
		ck(REG_IND, 32'h15);
		ck(m(16), 32'hffff);
		wr(g(7), 32'h7fff);
		wr(g(0), 32'hffff);
		wr(m(16), 32'h0);
		wr(m(18), 32'h1);
		exec({5'b11010, 3'h7, 2'h1, 2'h0, 1'b1, 3'b110}, 16'h0);
		ck(m(16), 32'h8000);
		ck(m(18), 32'h0);
		ck(g(7), 32'h7fff);
		ck(REG_IND, 32'h0e);
	endtask

	// register/storage word: displacement to register, indirect to storage
	task automatic t_aw_rs;
		wr(g(2), 32'h10);
		wr(g(3), 32'h1234);
		wr(m(20), 32'h1);
		exec({5'b11001, 3'h3, 2'h2, 2'h2, 1'b0, 3'b110}, 16'h4);
		ck(g(3), 32'h1235);
		ck(REG_IND, 32'h0);
		wr(m(22), 32'h18);
		wr(m(24), 32'hffff);
		exec({5'b11001, 3'h3, 2'h2, 2'h3, 1'b1, 3'b110}, 16'h6);
		ck(m(24), 32'h1234);
		ck(g(3), 32'h1235);
		ck(REG_IND, 32'h14);
		exec(16'h2000, 16'h0);
		ck(REG_PCHECK, 32'h0800);
		ck(REG_IND, 32'h14);
	endtask

	// storage/storage with post-increment, bad then good operand 2
	task automatic t_ss;
		wr(g(2), 32'h4);
		wr(g(3), 32'h40);
		exec({5'b10101, 2'h2, 2'h3, 2'h1, 2'h0, 1'b0, 2'b00}, 16'h0);
		ck(REG_PCHECK, 32'h4000);
		ck(g(2), 32'h6);
		wr(g(3), 32'ha);
		wr(m(6), 32'h3);
		wr(m(10), 32'h4);
		exec({5'b10101, 2'h2, 2'h3, 2'h1, 2'h0, 1'b0, 2'b00}, 16'h0);
		ck(m(10), 32'h7);
		ck(m(6), 32'h3);
		ck(REG_IND, 32'h0);
		wr(g(1), 32'h3e);
		exec({5'b10101, 2'h1, 2'h1, 2'h1, 2'h0, 1'b0, 2'b10}, 16'h0);
		ck(REG_PCHECK, 32'h4000);
		ck(g(1), 32'h42);
		wr(g(1), 32'h20);
		wr(g(2), 32'h28);
		wr(m(32), 32'h1);
		wr(m(34), 32'h8000);
		wr(m(40), 32'h0);
		wr(m(42), 32'h8000);
		exec({5'b10101, 2'h1, 2'h2, 2'h0, 2'h0, 1'b0, 2'b10}, 16'h0);
		ck(m(40), 32'h2);
		ck(m(42), 32'h0);
		ck(m(34), 32'h8000);
		ck(REG_IND, 32'h04);
	endtask

	// long format: zero field adds no register, indirect, odd pointer
	task automatic t_long;
		wr(g(0), 32'h100);
		wr(g(4), 32'h2);
		wr(m(16), 32'h14);
		wr(m(20), 32'h5);
		exec({5'b01101, 3'h4, 3'h0, 1'b1, 4'b1110}, 16'h10);
		ck(g(4), 32'h7);
		wr(m(16), 32'h15);
		exec({5'b01101, 3'h4, 3'h0, 1'b1, 4'b1110}, 16'h10);
		ck(REG_PCHECK, 32'h8000);
		ck(g(4), 32'h7);
		wr(g(6), 32'h10);
		exec({5'b01101, 3'h4, 3'h6, 1'b0, 4'b1110}, 16'h4);
		ck(g(4), 32'hc);
		wr(REG_IAR, 32'h3e);
		exec({5'b01101, 3'h4, 3'h6, 1'b0, 4'b1110}, 16'h4);
		ck(REG_PCHECK, 32'h4000);
		ck(g(4), 32'hc);
		wr(REG_IAR, 32'h0);
	endtask

	// a stuck bus ends the run
	always @(posedge clk_sys) begin
		if (tmo === 1'b1) begin
			mismatches++;
			conclude;
		end
	end

	initial begin
		nrst = 1'b0;
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		ck(REG_IND, 32'h0);
		ck(32'h300, 32'h0);
		t_acy;
		t_awrr;
		t_ad_rs;
		t_aw_rs;
		t_ss;
		t_long;
		conclude;
	end
endmodule
`default_nettype wire
